/* File: verilog/spbp_pkg.sv */
// Constants and carriers of the four-port serial block with boot port
// Operation
// R1: Four independent serial ports, each able to run asynchronously.
// R2: Async bit period never shorter than 64 system clocks.
// R3: Async characters carry seven or eight data bits.
// R4: Optional ninth bit per character marks an address byte.
// R5: Only ports 0 and 1 offer clocked mode; ports 2 and 3 async only.
// R6: Clocked mode shifts each bit on a dedicated serial clock line.
// R7: Clocked mode serial clock comes from either end, as configured.
// R8: Own serial clock period at least 160 system clocks (80% of /128).
// R9: Port 0 can cold-boot: receive a program, then release to run.
// R10: Host sets boot select pins to bootstrap code before reset release.
// R11: Boot select pins sampled at boot-up, then readable as inputs.
// R12: External reset input resets the processor core.
// R13: In async mode the boot port clock pin reads as an input.
// R14: Unused boot port gives two inputs and one output to software.
// R15: Status pin is a software-driven general output.
// R16: Async frame: low start, data LSB first, ninth, high stop.
package spbp_pkg;
   localparam int NPORT = 4;
   localparam int NSYNC = 2;
   // Bus map, byte addresses
   localparam logic [7:0] PORT_STRIDE = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DATA = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_BOOT = 8'h40;
   // Control register fields
   localparam int CTL_EN = 0;
   localparam int CTL_SEVEN = 1;
   localparam int CTL_NINTH = 2;
   localparam int CTL_CLKD = 3;
   localparam int CTL_CLKOUT = 4;
   localparam int CTL_DIV = 16;
   localparam logic [15:0] DIV_RST = 16'h0040;
   localparam logic [31:0] CTRL_RST = {DIV_RST, 16'h0000};
   // Status register fields
   localparam int STA_TXFULL = 0;
   localparam int STA_TXEMPTY = 1;
   localparam int STA_TXBUSY = 2;
   localparam int STA_RXVAL = 3;
   localparam int STA_RXOVR = 4;
   localparam int STA_RXFERR = 5;
   // Boot register fields
   localparam int BT_LATCH = 0;
   localparam int BT_LIVE = 2;
   localparam int BT_ACTIVE = 4;
   localparam int BT_SCLK = 5;
   localparam int BT_RXD = 6;
   localparam int BT_STATUS = 8;
   localparam int BT_GPOUT = 9;
   localparam int BT_DONE = 10;
   localparam logic [1:0] BOOT_EXT = 2'h0;
   localparam logic [2:0] BOOT_SETTLE = 3'h4;
   // Timing limits in system clocks
   localparam int ASYNC_DIV = 64;
   localparam int SYNC_PCT = 80;
   localparam int SYNC_DIV = 128;
   localparam int SYNC_MIN = (SYNC_DIV * 100 + SYNC_PCT - 1) / SYNC_PCT;
   localparam logic [15:0] ASYNC_MIN_CYC = 16'(ASYNC_DIV);
   localparam logic [15:0] SYNC_MIN_CYC = 16'(SYNC_MIN);
   // Port configuration and status carriers
   typedef struct packed {
      logic en;
      logic seven;
      logic ninth;
      logic clocked;
      logic clk_out;
      logic [15:0] div;
   } spbp_cfg_t;
   typedef struct packed {
      logic tx_full;
      logic tx_empty;
      logic tx_busy;
      logic rx_valid;
      logic rx_ovr;
      logic rx_ferr;
   } spbp_stat_t;
   localparam spbp_cfg_t BOOT_CFG = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                                      DIV_RST};
endpackage

/* File: verilog/spbp_top.sv */
// Serial port channels, transmit FIFO and bus-facing top
`timescale 1ns/100ps

// ****************************************
// Transmit FIFO
// ****************************************
module spbp_fifo #(
   parameter int W = 9,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW-1:0] LAST = AW'(D - 1);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } spbp_fifo_st_t;
   spbp_fifo_st_t st_ff, nxt_st;
   logic push, pop;

   // Honest full and empty from the fill count
   assign in_ready = st_ff.cnt != (AW + 1)'(D);
   assign out_valid = st_ff.cnt != '0;
   assign out_data = st_ff.mem[st_ff.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// ****************************************
// One serial port channel
// ****************************************
module spbp_chan
   import spbp_pkg::*;
#(
   parameter bit HAS_SYNC = 1'b0,
   parameter int FIFO_D = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Configuration and idle level of the data output
   input wire spbp_cfg_t cfg,
   input wire logic idle_lvl,
   // Transmit word from the bus
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [8:0] tx_data,
   // Received word to the bus
   input wire logic rx_pop,
   output logic [8:0] rx_data,
   output spbp_stat_t stat,
   // Pins
   input wire logic rxd_i,
   input wire logic sclk_i,
   output logic txd_o,
   output logic sclk_o,
   output logic sclk_oe_n,
   // Filtered pin levels
   output logic rx_lvl,
   output logic sc_lvl
);
   typedef struct packed {
      logic [2:0] rxs;
      logic [2:0] scs;
      logic rx_lvl;
      logic sc_lvl;
      logic tx_on;
      logic [15:0] tx_cnt;
      logic [3:0] tx_left;
      logic [10:0] tx_sh;
      logic txd;
      logic sck;
      logic sck_oe_n;
      logic rx_on;
      logic [15:0] rx_cnt;
      logic [3:0] rx_idx;
      logic [8:0] rx_sh;
      logic [8:0] rx_data;
      logic rx_valid;
      logic rx_ovr;
      logic rx_ferr;
   } spbp_chan_st_t;
   localparam spbp_chan_st_t ST_RST = '{rxs: 3'h7, scs: 3'h7,
      rx_lvl: 1'b1, sc_lvl: 1'b1, txd: 1'b1, sck: 1'b1,
      sck_oe_n: 1'b1, default: '0};
   spbp_chan_st_t st_ff, nxt_st;
   logic f_valid, f_pop;
   logic [8:0] f_data;
   logic sync_md, rx_f, sc_f, sc_rise, sc_fall;
   logic [3:0] nd, k;
   logic [15:0] per, half;
   logic [10:0] frame;
   logic [8:0] sh_new;

   spbp_fifo #(.W(9), .D(FIFO_D)) u_txq (
      .clk(clk),
      .resetn(resetn),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // Received word into the holding register
   function automatic spbp_chan_st_t deliver(spbp_chan_st_t s,
      logic [8:0] sh, logic [3:0] n, logic pop, logic sev, logic nin);
      logic [8:0] raw;
      raw = sh >> (4'd9 - n);
      s.rx_data = sev ? {nin & raw[7], 1'b0, raw[6:0]} :
                        {nin & raw[8], raw[7:0]};
      s.rx_ovr = s.rx_ovr | (s.rx_valid & ~pop);
      s.rx_valid = 1'b1;
      return s;
   endfunction

   // Channel behaviour
   always_comb begin
      nxt_st = st_ff;
      f_pop = 1'b0;
      frame = '1;
      // R5: clocked mode only on ports that have it
      sync_md = HAS_SYNC & cfg.clocked;
      // R3: seven or eight data bits
      nd = cfg.seven ? 4'h7 : 4'h8;
      // R4: ninth address bit in async mode
      k = nd + {3'h0, cfg.ninth & ~sync_md};
      // R2 R8: bit period clamped to the rate limit
      if (sync_md) begin
         per = (cfg.div < SYNC_MIN_CYC) ? SYNC_MIN_CYC : cfg.div;
      end else begin
         per = (cfg.div < ASYNC_MIN_CYC) ? ASYNC_MIN_CYC : cfg.div;
      end
      half = per >> 1;
      // Pin filters: a level counts once stages two and three agree
      nxt_st.rxs = {st_ff.rxs[1:0], rxd_i};
      nxt_st.scs = {st_ff.scs[1:0], sclk_i};
      rx_f = (st_ff.rxs[2] == st_ff.rxs[1]) ? st_ff.rxs[1] : st_ff.rx_lvl;
      sc_f = (st_ff.scs[2] == st_ff.scs[1]) ? st_ff.scs[1] : st_ff.sc_lvl;
      nxt_st.rx_lvl = rx_f;
      nxt_st.sc_lvl = sc_f;
      sc_rise = sc_f & ~st_ff.sc_lvl;
      sc_fall = ~sc_f & st_ff.sc_lvl;
      sh_new = {st_ff.rx_lvl, st_ff.rx_sh[8:1]};
      // Reading the data word frees the holding register
      if (rx_pop) begin
         nxt_st.rx_valid = 1'b0;
         nxt_st.rx_ovr = 1'b0;
         nxt_st.rx_ferr = 1'b0;
      end
      // R16: build the frame behind the start bit, stop bit is a one
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < nd) begin
            frame[i] = f_data[i];
         end
      end
      if (cfg.ninth) begin
         frame[nd] = f_data[8];
      end
      if (!cfg.en) begin
         // R14: idle port pin follows the software output level
         nxt_st.txd = idle_lvl;
         nxt_st.tx_on = 1'b0;
         nxt_st.rx_on = 1'b0;
         nxt_st.sck = 1'b1;
         nxt_st.sck_oe_n = 1'b1;
      end else if (!sync_md) begin
         // R13: clock pin stays an input in async mode
         nxt_st.sck = 1'b1;
         nxt_st.sck_oe_n = 1'b1;
         // R1 R16: async transmit, start bit then frame
         if (!st_ff.tx_on) begin
            nxt_st.txd = 1'b1;
            if (f_valid) begin
               f_pop = 1'b1;
               nxt_st.tx_on = 1'b1;
               nxt_st.txd = 1'b0;
               nxt_st.tx_sh = frame;
               nxt_st.tx_left = k + 4'h1;
               nxt_st.tx_cnt = per - 16'h0001;
            end
         end else if (st_ff.tx_cnt != '0) begin
            nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
         end else if (st_ff.tx_left == '0) begin
            nxt_st.tx_on = 1'b0;
         end else begin
            nxt_st.txd = st_ff.tx_sh[0];
            nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
            nxt_st.tx_left = st_ff.tx_left - 4'h1;
            nxt_st.tx_cnt = per - 16'h0001;
         end
         // R16: async receive, sample mid-bit, check start and stop
         if (!st_ff.rx_on) begin
            if (st_ff.rx_lvl && !rx_f) begin
               nxt_st.rx_on = 1'b1;
               nxt_st.rx_idx = '0;
               nxt_st.rx_cnt = half - 16'h0001;
            end
         end else if (st_ff.rx_cnt != '0) begin
            nxt_st.rx_cnt = st_ff.rx_cnt - 16'h0001;
         end else begin
            nxt_st.rx_cnt = per - 16'h0001;
            nxt_st.rx_idx = st_ff.rx_idx + 4'h1;
            if (st_ff.rx_idx == '0) begin
               nxt_st.rx_on = ~st_ff.rx_lvl;
            end else if (st_ff.rx_idx <= k) begin
               nxt_st.rx_sh = sh_new;
            end else begin
               nxt_st.rx_on = 1'b0;
               nxt_st = deliver(nxt_st, st_ff.rx_sh, k, rx_pop,
                                cfg.seven, cfg.ninth);
               nxt_st.rx_ferr = nxt_st.rx_ferr | ~st_ff.rx_lvl;
            end
         end
      end else if (cfg.clk_out) begin
         // R7: this end drives the serial clock
         nxt_st.rx_on = 1'b0;
         nxt_st.sck_oe_n = 1'b0;
         // R6: data changes on the falling edge, sampled on the rising
         if (!st_ff.tx_on) begin
            nxt_st.sck = 1'b1;
            if (f_valid) begin
               f_pop = 1'b1;
               nxt_st.tx_on = 1'b1;
               nxt_st.sck = 1'b0;
               nxt_st.txd = f_data[0];
               nxt_st.tx_sh = {3'h7, f_data[8:1]};
               nxt_st.tx_left = nd;
               nxt_st.tx_cnt = half - 16'h0001;
            end
         end else if (st_ff.tx_cnt != '0) begin
            nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
         end else begin
            nxt_st.tx_cnt = half - 16'h0001;
            if (!st_ff.sck) begin
               nxt_st.sck = 1'b1;
               nxt_st.rx_sh = sh_new;
               nxt_st.tx_left = st_ff.tx_left - 4'h1;
            end else if (st_ff.tx_left == '0) begin
               nxt_st.tx_on = 1'b0;
               nxt_st = deliver(nxt_st, st_ff.rx_sh, nd, rx_pop,
                                cfg.seven, 1'b0);
            end else begin
               nxt_st.sck = 1'b0;
               nxt_st.txd = st_ff.tx_sh[0];
               nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
            end
         end
      end else begin
         // R7: the far end drives the serial clock
         nxt_st.rx_on = 1'b0;
         nxt_st.sck = 1'b1;
         nxt_st.sck_oe_n = 1'b1;
         // R6: shift out on a falling edge, take in on a rising one
         if (sc_fall) begin
            if (!st_ff.tx_on) begin
               f_pop = f_valid;
               nxt_st.tx_on = 1'b1;
               nxt_st.tx_left = nd;
               nxt_st.txd = f_valid ? f_data[0] : 1'b1;
               nxt_st.tx_sh = f_valid ? {3'h7, f_data[8:1]} : '1;
            end else begin
               nxt_st.txd = st_ff.tx_sh[0];
               nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
            end
         end else if (sc_rise && st_ff.tx_on) begin
            nxt_st.rx_sh = sh_new;
            nxt_st.tx_left = st_ff.tx_left - 4'h1;
            if (st_ff.tx_left == 4'h1) begin
               nxt_st.tx_on = 1'b0;
               nxt_st = deliver(nxt_st, sh_new, nd, rx_pop,
                                cfg.seven, 1'b0);
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state
   assign txd_o = st_ff.txd;
   assign sclk_o = st_ff.sck;
   assign sclk_oe_n = st_ff.sck_oe_n;
   assign rx_lvl = st_ff.rx_lvl;
   assign sc_lvl = st_ff.sc_lvl;
   assign rx_data = st_ff.rx_data;
   assign stat = '{~tx_ready, ~f_valid, st_ff.tx_on, st_ff.rx_valid,
                   st_ff.rx_ovr, st_ff.rx_ferr};
endmodule

// ****************************************
// Top: Wishbone slave, ports, boot logic
// ****************************************
module spbp_top
   import spbp_pkg::*;
#(
   parameter int FIFO_D = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial pins
   input wire logic [NPORT-1:0] rxd_i,
   output logic [NPORT-1:0] txd_o,
   input wire logic [NSYNC-1:0] sclk_i,
   output logic [NSYNC-1:0] sclk_o,
   output logic [NSYNC-1:0] sclk_oe_n,
   // Boot port pins
   input wire logic boot_select_pin_0,
   input wire logic boot_select_pin_1,
   input wire logic external_reset_input_n,
   output logic core_reset_n,
   output logic status_o,
   output logic boot_active_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [NPORT-1:0][31:0] ctrl;
      logic [2:0] b0s;
      logic [2:0] b1s;
      logic [2:0] rss;
      logic [1:0] bsel;
      logic rst_lvl;
      logic [1:0] boot_lat;
      logic [2:0] settle;
      logic armed;
      logic boot_active;
      logic status;
      logic gp_out;
   } spbp_top_st_t;
   localparam spbp_top_st_t ST_RST = '{ctrl: {NPORT{CTRL_RST}},
      rss: 3'h7, rst_lvl: 1'b1, armed: 1'b1, gp_out: 1'b1, default: '0};
   spbp_top_st_t st_ff, nxt_st;
   spbp_cfg_t [NPORT-1:0] cfg;
   spbp_stat_t [NPORT-1:0] stat;
   logic [NPORT-1:0][8:0] rxw;
   logic [NPORT-1:0] tx_push, tx_rdy, rx_pop, rlv, slv, txw, sco, soe;
   logic [NPORT-1:0] scin;
   logic req, hit;
   logic [1:0] pi;
   logic [7:0] off;
   logic [31:0] wmask;

   // Port configuration from control words, boot overrides port 0
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         cfg[i] = '{st_ff.ctrl[i][CTL_EN], st_ff.ctrl[i][CTL_SEVEN],
                    st_ff.ctrl[i][CTL_NINTH], st_ff.ctrl[i][CTL_CLKD],
                    st_ff.ctrl[i][CTL_CLKOUT],
                    st_ff.ctrl[i][CTL_DIV+:16]};
      end
      // R9: bootstrap forces port 0 into async download mode
      if (st_ff.boot_active) begin
         cfg[0] = BOOT_CFG;
      end
   end

   // Channels; ports without clocked mode see an idle clock
   assign scin = {{(NPORT - NSYNC){1'b1}}, sclk_i};
   for (genvar g = 0; g < NPORT; g++) begin : g_port
      spbp_chan #(.HAS_SYNC(g < NSYNC), .FIFO_D(FIFO_D)) u_chan (
         .clk(clk),
         .resetn(resetn),
         .cfg(cfg[g]),
         .idle_lvl(g == 0 ? st_ff.gp_out : 1'b1),
         .tx_valid(tx_push[g]),
         .tx_ready(tx_rdy[g]),
         .tx_data(wb_dat_i[8:0]),
         .rx_pop(rx_pop[g]),
         .rx_data(rxw[g]),
         .stat(stat[g]),
         .rxd_i(rxd_i[g]),
         .sclk_i(scin[g]),
         .txd_o(txw[g]),
         .sclk_o(sco[g]),
         .sclk_oe_n(soe[g]),
         .rx_lvl(rlv[g]),
         .sc_lvl(slv[g])
      );
   end

   // Bus decode, answer and register effects
   always_comb begin
      nxt_st = st_ff;
      req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      hit = wb_adr_i < OFF_BOOT;
      pi = wb_adr_i[5:4];
      off = wb_adr_i & (PORT_STRIDE - 8'h01);
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      tx_push = '0;
      rx_pop = '0;
      // A data write waits for room in the FIFO before it is answered
      if (req && hit && off == OFF_DATA && wb_we_i) begin
         tx_push[pi] = 1'b1;
      end
      nxt_st.ack = req & ~(tx_push[pi] & ~tx_rdy[pi]);
      nxt_st.dat = '0;
      if (req && nxt_st.ack) begin
         if (hit && off == OFF_CTRL) begin
            if (wb_we_i) begin
               nxt_st.ctrl[pi] = (st_ff.ctrl[pi] & ~wmask) |
                                 (wb_dat_i & wmask);
               // R5: clocked bits do not exist on ports 2 and 3
               if (pi >= 2'(NSYNC)) begin
                  nxt_st.ctrl[pi][CTL_CLKD] = 1'b0;
                  nxt_st.ctrl[pi][CTL_CLKOUT] = 1'b0;
               end
            end
            nxt_st.dat = st_ff.ctrl[pi];
         end else if (hit && off == OFF_DATA && !wb_we_i) begin
            rx_pop[pi] = 1'b1;
            nxt_st.dat = {23'h000000, rxw[pi]};
         end else if (hit && off == OFF_STAT) begin
            nxt_st.dat[STA_TXFULL] = stat[pi].tx_full;
            nxt_st.dat[STA_TXEMPTY] = stat[pi].tx_empty;
            nxt_st.dat[STA_TXBUSY] = stat[pi].tx_busy;
            nxt_st.dat[STA_RXVAL] = stat[pi].rx_valid;
            nxt_st.dat[STA_RXOVR] = stat[pi].rx_ovr;
            nxt_st.dat[STA_RXFERR] = stat[pi].rx_ferr;
         end else if (wb_adr_i == OFF_BOOT) begin
            if (wb_we_i && wb_sel_i[1]) begin
               // R15: status pin under software control
               nxt_st.status = wb_dat_i[BT_STATUS];
               // R14: general output on the idle boot port data pin
               nxt_st.gp_out = wb_dat_i[BT_GPOUT];
               // R9: releasing boot lets the loaded program run
               if (wb_dat_i[BT_DONE]) begin
                  nxt_st.boot_active = 1'b0;
               end
            end
            // R11 R13 R14: latched and live pins readable as inputs
            nxt_st.dat[BT_LATCH+:2] = st_ff.boot_lat;
            nxt_st.dat[BT_LIVE+:2] = st_ff.bsel;
            nxt_st.dat[BT_ACTIVE] = st_ff.boot_active;
            nxt_st.dat[BT_SCLK] = slv[0];
            nxt_st.dat[BT_RXD] = rlv[0];
            nxt_st.dat[BT_STATUS] = st_ff.status;
            nxt_st.dat[BT_GPOUT] = st_ff.gp_out;
         end
      end
      // Boot pin filters: stages two and three must agree
      nxt_st.b0s = {st_ff.b0s[1:0], boot_select_pin_0};
      nxt_st.b1s = {st_ff.b1s[1:0], boot_select_pin_1};
      nxt_st.rss = {st_ff.rss[1:0], external_reset_input_n};
      if (st_ff.b0s[2] == st_ff.b0s[1]) begin
         nxt_st.bsel[0] = st_ff.b0s[1];
      end
      if (st_ff.b1s[2] == st_ff.b1s[1]) begin
         nxt_st.bsel[1] = st_ff.b1s[1];
      end
      if (st_ff.rss[2] == st_ff.rss[1]) begin
         nxt_st.rst_lvl = st_ff.rss[1];
      end
      // R12: external reset holds the core and rearms boot sampling
      if (!st_ff.rst_lvl) begin
         nxt_st.armed = 1'b1;
         nxt_st.settle = '0;
         nxt_st.boot_active = 1'b0;
      end else if (st_ff.armed) begin
         // R11 R10: sample boot select once the filters have settled
         if (st_ff.settle == BOOT_SETTLE) begin
            nxt_st.armed = 1'b0;
            nxt_st.boot_lat = st_ff.bsel;
            nxt_st.boot_active = st_ff.bsel == BOOT_EXT;
         end else begin
            nxt_st.settle = st_ff.settle + 3'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs, all from flip-flops
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.dat;
   assign txd_o = txw;
   assign sclk_o = sco[NSYNC-1:0];
   assign sclk_oe_n = soe[NSYNC-1:0];
   assign core_reset_n = st_ff.rst_lvl;
   assign status_o = st_ff.status;
   assign boot_active_o = st_ff.boot_active;
endmodule

/* File: test/spbp_top_sva.sv */
// Checker of bus, pin and boot timing of the serial block
`timescale 1ns/100ps
// ****
// Checker
// ****
module spbp_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins
   input wire logic [3:0] txd_o,
   input wire logic [1:0] sclk_o,
   input wire logic external_reset_input_n,
   input wire logic core_reset_n,
   input wire logic status_o,
   input wire logic boot_active_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Bus answer and idle data
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_read_answer: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
      && !wb_ack_o |=> wb_ack_o) else $error("read not answered");
   a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_status_cause: assert property ($changed(status_o) |->
      wb_ack_o || $past(wb_ack_o)) else $error("status moved alone");
   // Reset path and boot mode
   a_core_reset: assert property (!external_reset_input_n [*6]
      |=> !core_reset_n) else $error("core reset missed");
   a_boot_drop: assert property (!core_reset_n |=> !boot_active_o)
      else $error("boot mode kept in reset");
   // Minimum bit and clock widths
   a_start_len: assert property ($fell(txd_o[3]) |=> !txd_o[3] [*8])
      else $error("async bit too short");
   a_own_clock: assert property ($fell(sclk_o[1]) |=> !sclk_o[1] [*8])
      else $error("serial clock half too short");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_boot: cover property ($fell(boot_active_o));
   c_clk: cover property ($fell(sclk_o[1]));
endmodule
bind spbp_top spbp_chk chk (.*);

/* File: test/spbp_link_model.sv */
// Far-end async serial device on one line pair
`timescale 1ns/100ps
module spbp_link_model #(
   parameter int BIT_NS = 1600
) (
   // Lines
   input wire logic line_i,
   output logic line_o,
   // Last word caught
   output logic [7:0] got
);
   task automatic send(input logic [8:0] w, input int n);
      line_o = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < n; i++) begin
         line_o = w[i];
         #(BIT_NS);
      end
      line_o = 1'b1;
      #(BIT_NS);
   endtask
   // idle high, sample at bit centres
   initial begin
      line_o = 1'b1;
      got = 8'h00;
      forever begin
         @(negedge line_i);
         #(BIT_NS / 2);
         for (int i = 0; i < 8; i++) begin
            #(BIT_NS);
            got[i] = line_i;
         end
         #(BIT_NS);
      end
   end
endmodule

/* File: test/testbench.sv */
// Bench of the serial block: bus, async, clocked and boot cases
`timescale 1ns/100ps
module testbench;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} spbp_row_t;
   logic clk, resetn, cyc, stb, we, ack, scl0, rx0, bs0, bs1, ext_n;
   logic core_n, st, boot, lrx;
   logic [7:0] adr, lgot;
   logic [31:0] wd, rd, q;
   logic [3:0] txd;
   logic [1:0] sclo, oen;
   int fails, num_checks;
   spbp_row_t rows[10];
   spbp_top dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
      .wb_dat_o(rd), .wb_ack_o(ack), .rxd_i({1'b1, lrx, txd[1], rx0}),
      .txd_o(txd), .sclk_i({1'b1, scl0}), .sclk_o(sclo), .sclk_oe_n(oen),
      .boot_select_pin_0(bs0), .boot_select_pin_1(bs1),
      .external_reset_input_n(ext_n), .core_reset_n(core_n),
      .status_o(st), .boot_active_o(boot));
   spbp_link_model link (.line_i(txd[3]), .line_o(lrx), .got(lgot));
   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 500);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 500) fails++;
   endtask
   // Watchdog
   initial begin
      #200000;
      fails++;
      stop_test();
   end
   // Main sequence
   initial begin
      {cyc, stb, we, adr, wd, scl0, rx0, ext_n} = {11'h0, 32'h0, 3'h7};
      bs0 = 1'b0;
      bs1 = 1'b0;
      resetn = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
      chk({31'h0, boot}, 32'h1);
      $display("boot start test done");
      rows = '{'{0, 8'h00, 0, 32'h400000}, '{0, 8'h10, 0, 32'h400000},
         '{0, 8'h30, 0, 32'h400000}, '{0, 8'h38, 0, 32'h2},
         '{0, 8'h0C, 0, 0}, '{1, 8'h40, 32'h500, 0}, '{0, 8'h40, 0, 32'h160},
         '{1, 8'h20, 32'h40000F, 0}, '{0, 8'h20, 0, 32'h400007},
         '{1, 8'h30, 32'h400001, 0}};
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(q, rows[i].e);
      end
      chk({31'h0, st}, 32'h1);
      chk({31'h0, txd[0]}, 32'h0);
      $display("register test done");
      wb(1'b1, 8'h34, 32'hA5);
      repeat (700) @(posedge clk);
      chk({24'h0, lgot}, 32'hA5);
      link.send(9'h0D3, 8);
      wb(1'b0, 8'h24, 32'h0);
      chk(q, 32'h153);
      $display("async test done");
      wb(1'b1, 8'h00, 32'h400009);
      for (int i = 0; i < 8; i++) begin
         scl0 <= 1'b0;
         rx0 <= i[1] ^ i[2];
         repeat (4) @(posedge clk);
         scl0 <= 1'b1;
         repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h3C);
      wb(1'b1, 8'h10, 32'hA00019);
      wb(1'b1, 8'h14, 32'h5A);
      repeat (20) @(posedge clk);
      chk({31'h0, oen[1]}, 32'h0);
      repeat (1400) @(posedge clk);
      wb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h5A);
      $display("clocked test done");
      bs0 <= 1'b1;
      ext_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, core_n}, 32'h0);
      ext_n <= 1'b1;
      repeat (20) @(posedge clk);
      bs0 <= 1'b0;
      bs1 <= 1'b1;
      repeat (5) @(posedge clk);
      wb(1'b0, 8'h40, 32'h0);
      chk(q & 32'h1F, 32'h9);
      $display("external reset test done");
      stop_test();
   end
endmodule
